// File: rtl/odc_pkg.sv
package odc_pkg;

   localparam int ODC_CHANNELS = 8;
   localparam int ODC_PAR_INPUTS = 4;

   // Register byte offsets
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;

   // Per-channel command codes
   localparam logic [1:0] CMD_STBY = 2'h0;
   localparam logic [1:0] CMD_PAR = 2'h1;
   localparam logic [1:0] CMD_ON = 2'h2;
   localparam logic [1:0] CMD_OFF = 2'h3;

   // Values after power-on reset
   localparam logic [15:0] CMD_RESET = 16'hffff;
   localparam logic FRAME_ERR_RESET = 1'b1;

   // Field positions
   localparam int STAT_OT_LSB = 8;
   localparam int STAT_TER_BIT = 16;
   localparam int MODE_DRV_LSB = 8;
   localparam int MODE_STATE_LSB = 16;
   localparam int MODE_POWERUP_BIT = 18;
   localparam int MODE_LOWQ_BIT = 19;
   localparam int MODE_REDQ_BIT = 20;

   // Timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int OC_DELAY_US = 15;
   localparam int OC_FILTER_CYCLES =
      (OC_DELAY_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int OC_CNT_W = $clog2(OC_FILTER_CYCLES + 1);

   typedef enum {
      ST_UVLO,
      ST_LOWQ,
      ST_NORMAL,
      ST_LIMP
   } odc_state_t;

   typedef struct packed {
      logic enable;
      logic limp_home_pin;
      logic analog_supply;
      logic logic_supply;
      logic [3:0] par_in;
      logic [7:0] overcurrent;
      logic [7:0] overtemp;
   } odc_pins_t;

endpackage

// File: rtl/odc_channel_ctrl.sv
`timescale 1ns/1ps

// How it works
// - Overcurrent trip latches the channel driver off
// - Overcurrent shorter than filter delay is ignored
// - Overcurrent sensed at turn-on and while on
// - Standby code or power-on reset clears faults
// - Commands accepted only when powered and enabled
// - Enable rising restores all settings to defaults
// - Each channel mode selected independently by command
// - Reset sets commands off, frame error set
// - Limp-home ignores logic supply, analog supply acts
// - Power-up global off has diagnostic current off
// - Codes 11 off, 10 on, 01 parallel, 00 standby
// - Lockout forces outputs off, limp-home overrides enable
// - Standby disables diagnostics; all standby reduces quiescent
// - Enable and limp-home low give lowest quiescent
// - Parallel input n drives channels n and n+4
// - Off channel leaves pair partner on parallel input
// - Limp-home: channels 1-4 follow inputs, 5-8 off
// - Limp-home ignores commands, faults still sensed, reported
// - Leaving limp-home resets registers, diagnostics off
// - Leaving limp-home into global off sets frame error
// - Analog supply drop forces lockout, limp faults cleared
// - Enable or limp-home rising powers device up
// - Per-channel over-temperature latches only that channel off
// - Leaving lockout, or lowest quiescent into normal, sets frame error
module odc_channel_ctrl
   import odc_pkg::*;
#(
   parameter int CHANNELS = ODC_CHANNELS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic enable,
   input wire logic limp_home_pin,
   input wire logic analog_supply,
   input wire logic logic_supply,
   input wire logic [3:0] par_in,
   input wire logic [7:0] overcurrent,
   input wire logic [7:0] overtemp,
   output logic [7:0] driver_output,
   output logic [7:0] diag_current_en,
   output logic reduced_quiescent,
   output logic lowest_quiescent_state
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   odc_pins_t pins_raw;
   odc_pins_t pins_meta;
   odc_pins_t pins;

   assign pins_raw = '{enable: enable, limp_home_pin: limp_home_pin,
                       analog_supply: analog_supply, logic_supply: logic_supply,
                       par_in: par_in, overcurrent: overcurrent,
                       overtemp: overtemp};

   // All pins are asynchronous to hclk; supplies resolve as "not ok" at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_meta <= '0;
         pins <= '0;
      end else begin
         pins_meta <= pins_raw;
         pins <= pins_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Device mode state machine

   odc_state_t state;
   odc_state_t next_state;
   logic clear_all;
   logic enter_normal;

   function automatic logic powered_down(input odc_state_t s);
      powered_down = (s == ST_UVLO) || (s == ST_LOWQ);
   endfunction

   always_comb begin
      next_state = state;
      case (state)
         ST_UVLO: begin
            if (pins.analog_supply && pins.limp_home_pin) begin
               next_state = ST_LIMP;
            end else if (pins.analog_supply && pins.logic_supply) begin
               next_state = pins.enable ? ST_NORMAL : ST_LOWQ;
            end
         end
         ST_LOWQ: begin
            if (!pins.analog_supply) begin
               next_state = ST_UVLO;
            end else if (pins.limp_home_pin) begin
               next_state = ST_LIMP;
            end else if (!pins.logic_supply) begin
               next_state = ST_UVLO;
            end else if (pins.enable) begin
               next_state = ST_NORMAL;
            end
         end
         ST_NORMAL: begin
            // Limp-home outranks a logic supply drop, so faults survive it
            if (!pins.analog_supply) begin
               next_state = ST_UVLO;
            end else if (pins.limp_home_pin) begin
               next_state = ST_LIMP;
            end else if (!pins.logic_supply) begin
               next_state = ST_UVLO;
            end else if (!pins.enable) begin
               next_state = ST_LOWQ;
            end
         end
         ST_LIMP: begin
            // Logic supply is not watched while limp-home is held, only on leaving it
            if (!pins.analog_supply) begin
               next_state = ST_UVLO;
            end else if (!pins.limp_home_pin) begin
               if (!pins.logic_supply) begin
                  next_state = ST_UVLO;
               end else begin
                  next_state = pins.enable ? ST_NORMAL : ST_LOWQ;
               end
            end
         end
         default: next_state = ST_UVLO;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_UVLO;
      end else begin
         state <= next_state;
      end
   end

   // Every path into normal operation is a fresh power-up: lockout exit,
   // enable rising out of lowest quiescent, or limp-home exit
   assign clear_all = powered_down(state) ||
                      (state == ST_LIMP && next_state != ST_LIMP);
   assign enter_normal = (state != ST_NORMAL) && (next_state == ST_NORMAL);

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave

   logic dp_write;
   logic dp_sel;
   logic [7:0] dp_addr;
   logic addr_phase;
   logic cmd_write;

   assign addr_phase = hsel && hready && htrans[1];
   // Zero wait states, so a request is answered in its own data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_sel <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hready) begin
         dp_sel <= addr_phase;
         dp_write <= addr_phase && hwrite;
         dp_addr <= haddr[7:0];
      end
   end

   // Commands are dropped outside normal operation
   assign cmd_write = dp_sel && dp_write && (dp_addr == ADDR_CMD) &&
                      (state == ST_NORMAL);

   ////////////////////////////////////////////////////////////////////////////
   // Command register, frame error flag and power-up diagnostic gate

   logic [15:0] cmd;
   logic frame_err;
   logic powerup;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd <= CMD_RESET;
      end else if (clear_all) begin
         cmd <= CMD_RESET;
      end else if (cmd_write) begin
         cmd <= hwdata[15:0];
      end
   end

   // A set on entering normal operation wins over a clearing command
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_err <= FRAME_ERR_RESET;
      end else if (state == ST_UVLO || enter_normal) begin
         frame_err <= 1'b1;
      end else if (cmd_write) begin
         frame_err <= 1'b0;
      end
   end

   // Keeps diagnostic current off until software commands the channels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         powerup <= 1'b1;
      end else if (clear_all) begin
         powerup <= 1'b1;
      end else if (cmd_write) begin
         powerup <= 1'b0;
      end
   end

   // Channel n owns command bits [2n+1:2n]
   function automatic logic [1:0] chan_mode(input logic [15:0] c, input int ch);
      chan_mode = c[2 * ch +: 2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel drive, overload filter and fault latches

   logic [7:0] overload;
   logic [7:0] overheat;
   logic [7:0] next_drive;
   logic [7:0] next_diag;
   logic [7:0] standby;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         logic [OC_CNT_W-1:0] oc_cnt;
         logic fault_clr;
         logic par_bit;
         logic oc_expired;

         assign par_bit = pins.par_in[g % ODC_PAR_INPUTS];
         assign standby[g] = (chan_mode(cmd, g) == CMD_STBY);
         // Only a standby command or clear_all clears; parallel input toggles never do
         assign fault_clr = clear_all || (state == ST_NORMAL && standby[g]);
         assign oc_expired = (oc_cnt == OC_CNT_W'(OC_FILTER_CYCLES - 1)) &&
                             pins.overcurrent[g] && driver_output[g];

         always_comb begin
            next_drive[g] = 1'b0;
            case (state)
               ST_NORMAL: begin
                  case (chan_mode(cmd, g))
                     CMD_ON: next_drive[g] = 1'b1;
                     CMD_PAR: next_drive[g] = par_bit;
                     default: next_drive[g] = 1'b0;
                  endcase
               end
               ST_LIMP: begin
                  // Upper channels have no input of their own here
                  next_drive[g] = (g < ODC_PAR_INPUTS) ? par_bit : 1'b0;
               end
               default: next_drive[g] = 1'b0;
            endcase
            if (overload[g] || overheat[g]) begin
               next_drive[g] = 1'b0;
            end
         end

         always_comb begin
            next_diag[g] = (state == ST_NORMAL) && !powerup && !next_drive[g] &&
                           !standby[g];
         end

         // Counts only while driving, so turn-on into a short and a later
         // short are caught alike; saturates so a held short never wraps
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               oc_cnt <= '0;
            end else if (fault_clr || !pins.overcurrent[g] || !driver_output[g]) begin
               oc_cnt <= '0;
            end else if (oc_cnt != OC_CNT_W'(OC_FILTER_CYCLES)) begin
               oc_cnt <= oc_cnt + OC_CNT_W'(1);
            end
         end

         // Set wins over a standby clear in the same cycle
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               overload[g] <= 1'b0;
            end else if (oc_expired) begin
               overload[g] <= 1'b1;
            end else if (fault_clr) begin
               overload[g] <= 1'b0;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               overheat[g] <= 1'b0;
            end else if (pins.overtemp[g] && !powered_down(state)) begin
               overheat[g] <= 1'b1;
            end else if (fault_clr) begin
               overheat[g] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         driver_output <= '0;
         diag_current_en <= '0;
         reduced_quiescent <= 1'b0;
         lowest_quiescent_state <= 1'b0;
      end else begin
         driver_output <= next_drive;
         diag_current_en <= next_diag;
         reduced_quiescent <= (state == ST_NORMAL) && (&standby);
         lowest_quiescent_state <= (state == ST_LOWQ);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, taken in the address phase so it stands registered

   logic [31:0] status_word;
   logic [31:0] mode_word;

   // Upper bits read as zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[7:0] = overload;
      status_word[STAT_OT_LSB +: 8] = overheat;
      status_word[STAT_TER_BIT] = frame_err;
   end

   // Exposes the device state so software can tell limp-home from lockout
   always_comb begin
      mode_word = 32'h0000_0000;
      mode_word[7:0] = diag_current_en;
      mode_word[MODE_DRV_LSB +: 8] = driver_output;
      mode_word[MODE_STATE_LSB +: 2] = 2'(state);
      mode_word[MODE_POWERUP_BIT] = powerup;
      mode_word[MODE_LOWQ_BIT] = lowest_quiescent_state;
      mode_word[MODE_REDQ_BIT] = reduced_quiescent;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            ADDR_CMD: hrdata <= {16'h0000, cmd};
            ADDR_STATUS: hrdata <= status_word;
            ADDR_MODE: hrdata <= mode_word;
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule // odc_channel_ctrl

// File: tb/odc_host_pins.sv
`timescale 1ns/1ps

// Host side of the parallel inputs; the link clock stands still outside PWM bursts
module odc_host_pins (
   input wire logic pwm_run,
   input wire logic [3:0] level,
   output logic [3:0] par_in
);
   logic link_clk = 1'b0;
   always #32 if (pwm_run) link_clk = ~link_clk;
   // Toggling only, never used to clear a latched fault
   assign par_in = pwm_run ? (level & {4{link_clk}}) : level;
endmodule // odc_host_pins

// File: tb/odc_channel_ctrl_chk.sv
`timescale 1ns/1ps

module odc_channel_ctrl_chk
   import odc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic enable,
   input wire logic limp_home_pin,
   input wire logic analog_supply,
   input wire logic logic_supply,
   input wire logic [3:0] par_in,
   input wire logic [7:0] overcurrent,
   input wire logic [7:0] overtemp,
   input wire logic [7:0] driver_output,
   input wire logic [7:0] diag_current_en,
   input wire logic reduced_quiescent,
   input wire logic lowest_quiescent_state
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   localparam int OC_LIM = OC_FILTER_CYCLES + 8;
   logic [15:0] oc_run;
   // Sync delay plus filter plus output register bound the time on into a short
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) oc_run <= '0;
      else oc_run <= (overcurrent[0] && driver_output[0]) ? oc_run + 16'h0001 : '0;
   end
   sequence limp_held;
      (limp_home_pin && analog_supply)[*6];
   endsequence
   sequence limp_clean;
      (limp_home_pin && analog_supply && overcurrent == 0 && overtemp == 0 && $stable(par_in))[*7];
   endsequence
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
   oc_bound_a: assert property (oc_run <= OC_LIM) else $error("overload not latched");
   lowq_entry_a: assert property ((!enable && !limp_home_pin && analog_supply && logic_supply)[*8]
      |-> lowest_quiescent_state) else $error("lowest quiescent missing");
   lowq_quiet_a: assert property (lowest_quiescent_state |-> driver_output == 0
      && diag_current_en == 0) else $error("drive in lowest quiescent");
   limp_upper_a: assert property (limp_held |-> driver_output[7:4] == 0
      && diag_current_en == 0) else $error("upper channels on in limp");
   limp_follow_a: assert property (limp_clean |-> driver_output[3:0] == par_in)
      else $error("limp outputs not following inputs");
   uvlo_off_a: assert property ((!analog_supply)[*5] |-> driver_output == 0)
      else $error("outputs on in lockout");
   stby_quiet_a: assert property (reduced_quiescent |-> driver_output == 0
      && diag_current_en == 0) else $error("standby not quiet");
endmodule // odc_channel_ctrl_chk

bind odc_channel_ctrl odc_channel_ctrl_chk chk_u (.hclk, .hresetn, .hreadyout, .hresp, .enable,
   .limp_home_pin, .analog_supply, .logic_supply, .par_in, .overcurrent, .overtemp,
   .driver_output, .diag_current_en, .reduced_quiescent, .lowest_quiescent_state);

// File: tb/odc_channel_ctrl_bench.sv
`timescale 1ns/1ps

module odc_channel_ctrl_bench
   import odc_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rdat;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, enable = 1'b1, limp = 1'b0, ana = 1'b1, lsup = 1'b1;
   logic pwm_run = 1'b0, rq, lq;
   logic [3:0] level = 4'h0, par_in;
   logic [7:0] oc = 8'h00, ot = 8'h00, drv, diag;
   int error_cnt = 0, checks = 0;
   always #4 hclk = ~hclk;

   odc_host_pins host_u (.pwm_run(pwm_run), .level(level), .par_in(par_in));
   odc_channel_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enable(enable),
      .limp_home_pin(limp), .analog_supply(ana), .logic_supply(lsup), .par_in(par_in),
      .overcurrent(oc), .overtemp(ot), .driver_output(drv), .diag_current_en(diag),
      .reduced_quiescent(rq), .lowest_quiescent_state(lq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic w(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic close_out;
      if (error_cnt == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmd(input logic [31:0] d);
      bus(1'b1, ADDR_CMD, d);
      w(8);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      chk(rdat, e);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(ADDR_CMD, 32'h0000_ffff);
      rd(ADDR_STATUS, 32'h0001_0000);
      rd(ADDR_MODE, 32'h0006_0000);
   endtask
   // Ch0 on, ch1 par, ch2 stby, ch3 off, ch4 par, ch5 off, ch6 on, ch7 off
   task automatic t_modes;
      level <= 4'h3;
      cmd(32'h0000_edc6);
      chk({24'h0, drv}, 32'h0000_0053);
      level <= 4'h0;
      w(8);
      chk({24'h0, drv}, 32'h0000_0041);
      chk({24'h0, diag}, 32'h0000_00ba);
   endtask
   task automatic t_overload;
      oc[0] <= 1'b1;
      w(100);
      oc[0] <= 1'b0;
      w(8);
      chk({31'h0, drv[0]}, 32'h1);
      oc[0] <= 1'b1;
      w(1900);
      chk({31'h0, drv[0]}, 32'h0);
      oc[0] <= 1'b0;
      ot[1] <= 1'b1;
      pwm_run <= 1'b1;
      level <= 4'hf;
      w(40);
      ot[1] <= 1'b0;
      pwm_run <= 1'b0;
      level <= 4'h2;
      w(8);
      chk({24'h0, drv}, 32'h0000_0040);
      level <= 4'h0;
      rd(ADDR_STATUS, 32'h0000_0201);
      cmd(32'h0000_edc0);
      cmd(32'h0000_edc6);
      chk({24'h0, drv}, 32'h0000_0041);
      ot[6] <= 1'b1;
      w(8);
      ot[6] <= 1'b0;
      chk({24'h0, drv}, 32'h0000_0001);
      cmd(32'h0000_cdc6);
      cmd(32'h0000_edc6);
      chk({24'h0, drv}, 32'h0000_0041);
      cmd(32'h0000_0000);
      chk({31'h0, rq}, 32'h1);
   endtask
   task automatic t_limp;
      limp <= 1'b1;
      lsup <= 1'b0;
      level <= 4'h5;
      w(8);
      chk({24'h0, drv}, 32'h0000_0005);
      cmd(32'h0000_aaaa);
      chk({24'h0, drv}, 32'h0000_0005);
      rd(ADDR_CMD, 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0000);
      rd(ADDR_MODE, 32'h0003_0500);
      lsup <= 1'b1;
      limp <= 1'b0;
      level <= 4'h0;
      w(8);
      rd(ADDR_STATUS, 32'h0001_0000);
      rd(ADDR_CMD, 32'h0000_ffff);
      chk({24'h0, diag}, 32'h0);
   endtask
   task automatic t_power;
      enable <= 1'b0;
      w(8);
      chk({31'h0, lq}, 32'h1);
      enable <= 1'b1;
      w(8);
      rd(ADDR_STATUS, 32'h0001_0000);
      cmd(32'h0000_aaaa);
      chk({24'h0, drv}, 32'h0000_00ff);
      ana <= 1'b0;
      w(8);
      chk({24'h0, drv}, 32'h0);
      ana <= 1'b1;
      w(8);
      rd(ADDR_CMD, 32'h0000_ffff);
      rd(ADDR_STATUS, 32'h0001_0000);
      chk({24'h0, diag}, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      w(2);
      hresetn <= 1'b1;
      w(8);
      t_reset();
      t_modes();
      t_overload();
      t_limp();
      t_power();
      close_out();
   end
   // Whole run is a few thousand cycles
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
endmodule // odc_channel_ctrl_bench
